// file: rtl/dbc_battery_ctrl.sv
// Converter control and battery switch top with APB register file
`timescale 1ns/1ps
module dbc_battery_ctrl
  import dbc_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [5:0] i_battery_sense_in,
  input wire logic i_supply_monitor_high,
  input wire logic i_supply_monitor_low,
  input wire logic i_ringing,
  input wire logic i_off_hook,
  input wire logic [5:0] i_active_target,
  output logic o_switch_drive_out,
  output logic o_switch_feedforward_out,
  output logic o_low_battery_sel,
  output logic o_monitor_calibrate
);
  localparam int DEB_W = $clog2(DEBOUNCE_LEN + 1);
  localparam int CAL_W = $clog2(CAL_CYCLES + 1);

  dbc_pwm_if pwm ();

  logic [7:0] powerdown_reg;
  logic [7:0] feed_sel_reg;
  logic [7:0] line_feed_reg;
  logic [5:0] ring_bat_reg;
  logic [5:0] low_bat_reg;
  logic [7:0] period_reg;
  logic [4:0] off_time_reg;
  logic [7:0] options_reg;
  logic [7:0] ind_lo_reg;
  logic [7:0] ind_hi_reg;
  logic [7:0] ind_addr_reg;
  logic [15:0] headroom_reg;
  logic cal_reg;
  logic [CAL_W-1:0] cal_cnt_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic mapped;
  logic wr_en;
  logic acc;

  // Access completes one cycle after setup; no wait states beyond that
  assign acc = i_psel && i_penable && pready_reg;
  assign wr_en = acc && i_pwrite && i_pstrb[0];

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == dbc_addr(idx);
  endfunction

  always_comb begin
    rd_next = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(i_paddr, IDX_POWERDOWN)) begin
      rd_next[7:0] = powerdown_reg;
    end else if (hit(i_paddr, IDX_IND_DATA_LO)) begin
      rd_next[7:0] = ind_lo_reg;
    end else if (hit(i_paddr, IDX_IND_DATA_HI)) begin
      rd_next[7:0] = ind_hi_reg;
    end else if (hit(i_paddr, IDX_IND_ADDR)) begin
      rd_next[7:0] = ind_addr_reg;
    end else if (hit(i_paddr, IDX_IND_CTRL)) begin
      rd_next[7:0] = 8'h00;
    end else if (hit(i_paddr, IDX_FEED_SEL)) begin
      rd_next[7:0] = feed_sel_reg;
    end else if (hit(i_paddr, IDX_LINE_FEED)) begin
      rd_next[7:0] = line_feed_reg;
    end else if (hit(i_paddr, IDX_RING_BAT)) begin
      rd_next[5:0] = ring_bat_reg;
    end else if (hit(i_paddr, IDX_LOW_BAT)) begin
      rd_next[5:0] = low_bat_reg;
    end else if (hit(i_paddr, IDX_PERIOD)) begin
      rd_next[7:0] = period_reg;
    end else if (hit(i_paddr, IDX_SW_DELAY)) begin
      rd_next[7:0] = {cal_reg, 2'b00, off_time_reg};
    end else if (hit(i_paddr, IDX_OPTIONS)) begin
      rd_next[7:0] = options_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= i_psel && !i_penable && !pready_reg;
      pslverr_reg <= i_psel && !i_penable && !mapped;
      prdata_reg <= (i_psel && !i_penable && !i_pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      powerdown_reg <= RST_POWERDOWN;
      feed_sel_reg <= RST_ZERO;
      line_feed_reg <= RST_ZERO;
      ring_bat_reg <= RST_ZERO[5:0];
      low_bat_reg <= RST_ZERO[5:0];
      period_reg <= RST_PERIOD;
      off_time_reg <= RST_ZERO[4:0];
      options_reg <= RST_ZERO;
    end else if (wr_en) begin
      if (hit(i_paddr, IDX_POWERDOWN)) powerdown_reg <= i_pwdata[7:0];
      if (hit(i_paddr, IDX_FEED_SEL)) feed_sel_reg <= i_pwdata[7:0];
      if (hit(i_paddr, IDX_LINE_FEED)) line_feed_reg <= i_pwdata[7:0];
      if (hit(i_paddr, IDX_RING_BAT)) ring_bat_reg <= i_pwdata[5:0];
      if (hit(i_paddr, IDX_LOW_BAT)) low_bat_reg <= i_pwdata[5:0];
      if (hit(i_paddr, IDX_PERIOD)) period_reg <= i_pwdata[7:0];
      if (hit(i_paddr, IDX_SW_DELAY)) off_time_reg <= i_pwdata[4:0];
      if (hit(i_paddr, IDX_OPTIONS)) options_reg <= i_pwdata[7:0];
    end
  end

  // Indirect window: address write loads data, control write stores it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ind_lo_reg <= RST_ZERO;
      ind_hi_reg <= RST_ZERO;
      ind_addr_reg <= RST_ZERO;
    end else if (wr_en) begin
      if (hit(i_paddr, IDX_IND_DATA_LO)) ind_lo_reg <= i_pwdata[7:0];
      if (hit(i_paddr, IDX_IND_DATA_HI)) ind_hi_reg <= i_pwdata[7:0];
      if (hit(i_paddr, IDX_IND_ADDR)) begin
        ind_addr_reg <= i_pwdata[7:0];
        ind_lo_reg <= (i_pwdata[7:0] == IND_HEADROOM) ? headroom_reg[7:0] : 8'h00;
        ind_hi_reg <= (i_pwdata[7:0] == IND_HEADROOM) ? headroom_reg[15:8] : 8'h00;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      headroom_reg <= RST_HEADROOM;
    end else if (wr_en && hit(i_paddr, IDX_IND_CTRL) && ind_addr_reg == IND_HEADROOM) begin
      headroom_reg <= {ind_hi_reg, ind_lo_reg};
    end
  end

  // Calibration starts only while the converter is on
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_reg <= 1'b0;
      cal_cnt_reg <= '0;
    end else if (!cal_reg) begin
      if (wr_en && hit(i_paddr, IDX_SW_DELAY) && i_pwdata[BIT_CAL]
          && !powerdown_reg[BIT_CONV_OFF]) begin
        cal_reg <= 1'b1;
        cal_cnt_reg <= '0;
      end
    end else if (cal_cnt_reg == CAL_W'(CAL_CYCLES - 1)) begin
      cal_reg <= 1'b0;
    end else begin
      cal_cnt_reg <= cal_cnt_reg + 1'b1;
    end
  end

  // Regulation target and error
  logic [3:0] head_lim;
  logic [6:0] active_tgt;
  logic [6:0] target_reg;
  logic signed [8:0] err_now;
  logic signed [8:0] err_prev_reg;
  logic signed [9:0] err_sum;
  logic signed [8:0] err_f;
  logic [7:0] width_reg;
  logic [7:0] step;
  logic fast;

  assign head_lim = feed_sel_reg[BIT_RANGE] ? HEADROOM_MAX_WIDE : HEADROOM_MAX_NARROW;
  assign active_tgt = {1'b0, i_active_target}
    + {3'b000, (headroom_reg[3:0] > head_lim) ? head_lim : headroom_reg[3:0]};

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      target_reg <= 7'h00;
    end else if (i_ringing) begin
      target_reg <= {1'b0, ring_bat_reg};
    end else begin
      target_reg <= (active_tgt < {1'b0, low_bat_reg}) ? {1'b0, low_bat_reg} : active_tgt;
    end
  end

  assign err_now = $signed({2'b00, target_reg}) - $signed({3'b000, i_battery_sense_in});
  assign err_sum = {err_now[8], err_now} + {err_prev_reg[8], err_prev_reg};
  assign err_f = options_reg[BIT_FILT] ? err_sum[9:1] : err_now;
  assign fast = options_reg[BIT_FAST] && (err_f > FAST_THRESH || err_f < -FAST_THRESH);
  assign step = fast ? FAST_STEP : 8'h01;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      err_prev_reg <= 9'sh000;
    end else if (pwm.start) begin
      err_prev_reg <= err_now;
    end
  end

  // Width moves once a period so each step settles before the next
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      width_reg <= 8'h00;
    end else if (powerdown_reg[BIT_CONV_OFF]) begin
      width_reg <= 8'h00;
    end else if (pwm.start && err_f > 9'sh000) begin
      width_reg <= (width_reg > 8'hff - step) ? 8'hff : width_reg + step;
    end else if (pwm.start && err_f < 9'sh000) begin
      width_reg <= (width_reg < step) ? 8'h00 : width_reg - step;
    end
  end

  assign pwm.period = period_reg;
  assign pwm.off_time = off_time_reg;
  assign pwm.width = width_reg;
  assign pwm.enable = !powerdown_reg[BIT_CONV_OFF];
  assign pwm.overload = i_supply_monitor_high || i_supply_monitor_low;

  dbc_pwm_core u_core (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .bus(pwm)
  );

  // Battery switch state
  dbc_bsel_t bs_reg;
  logic [DEB_W-1:0] deb_cnt_reg;
  logic auto_sel;
  logic want_low;
  assign auto_sel = line_feed_reg[BIT_AUTO];
  assign want_low = i_off_hook && !i_ringing;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bs_reg <= BS_HIGH;
    end else if (!auto_sel) begin
      bs_reg <= BS_HIGH;
    end else begin
      case (bs_reg)
        BS_HIGH: begin
          if (want_low) begin
            bs_reg <= options_reg[BIT_DEB] ? BS_DEB : BS_LOW;
          end
        end
        BS_DEB: begin
          if (!want_low) begin
            bs_reg <= BS_HIGH;
          end else if (deb_cnt_reg == DEB_W'(DEBOUNCE_LEN - 1)) begin
            bs_reg <= BS_LOW;
          end
        end
        BS_LOW: begin
          if (!want_low) begin
            bs_reg <= BS_HIGH;
          end
        end
        default: bs_reg <= BS_HIGH;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      deb_cnt_reg <= '0;
    end else if (bs_reg != BS_DEB) begin
      deb_cnt_reg <= '0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_low_battery_sel <= 1'b0;
      o_switch_drive_out <= 1'b0;
      o_switch_feedforward_out <= 1'b1;
    end else begin
      o_low_battery_sel <= auto_sel ? (bs_reg == BS_LOW) : feed_sel_reg[BIT_MANUAL_BATTERY_FEED_SELECT];
      o_switch_drive_out <= pwm.drive;
      o_switch_feedforward_out <= !pwm.drive;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_monitor_calibrate = cal_reg;

  AST_POWER_OFF_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    powerdown_reg[BIT_CONV_OFF] |-> ##2 !o_switch_drive_out)
    else $error("converter switching while powered down");
  AST_RING_TARGET: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_ringing |=> target_reg == {1'b0, $past(ring_bat_reg)})
    else $error("ringing target not high battery");
  AST_ACTIVE_TARGET: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(i_ringing) |=> target_reg >= {1'b0, $past(i_active_target)}
    && (target_reg <= {1'b0, $past(i_active_target)} + {3'b000, HEADROOM_MAX_WIDE}
    || target_reg == {1'b0, $past(low_bat_reg)}))
    else $error("target not back to tracking");
  AST_MANUAL_SEL: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !auto_sel |=> o_low_battery_sel == $past(feed_sel_reg[BIT_MANUAL_BATTERY_FEED_SELECT]))
    else $error("manual battery select not followed");
  AST_AUTO_OFFHOOK: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    auto_sel && !options_reg[BIT_DEB] && bs_reg == BS_HIGH && want_low
    ##1 auto_sel && want_low |=> o_low_battery_sel)
    else $error("no low battery after off-hook");
  AST_DEB_ABORT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    bs_reg == BS_DEB && !want_low && auto_sel |=> bs_reg == BS_HIGH ##1 !o_low_battery_sel)
    else $error("pending switch not abandoned");
  AST_DEB_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(bs_reg == BS_DEB) |-> (bs_reg == BS_DEB || !want_low || !auto_sel)[*8]
    ##0 !o_low_battery_sel)
    else $error("debounce ended too early");
  // Length of the current low stretch on the drive pin, saturating
  logic [8:0] low_run_reg;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_run_reg <= 9'h1ff;
    end else if (o_switch_drive_out) begin
      low_run_reg <= 9'h000;
    end else if (low_run_reg != 9'h1ff) begin
      low_run_reg <= low_run_reg + 9'h001;
    end
  end

  AST_MIN_OFF: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(o_switch_drive_out) && $stable(off_time_reg) |->
    low_run_reg >= {4'h0, off_time_reg} + MIN_OFF_BASE)
    else $error("off time shorter than field plus four");
  AST_AUTO_ONHOOK: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    auto_sel && !want_low ##1 auto_sel |=> !o_low_battery_sel)
    else $error("high battery not restored on-hook");
  AST_FAST_STEP: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    pwm.start && !powerdown_reg[BIT_CONV_OFF] && options_reg[BIT_FAST]
    && err_f > FAST_THRESH && width_reg < 8'hfc |=> width_reg == $past(width_reg) + FAST_STEP)
    else $error("fast error step not taken");
  AST_INDIRECT_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    wr_en && hit(i_paddr, IDX_IND_CTRL) && ind_addr_reg == IND_HEADROOM
    |=> headroom_reg == {$past(ind_hi_reg), $past(ind_lo_reg)})
    else $error("indirect write lost");
endmodule // dbc_battery_ctrl

// file: rtl/dbc_pkg.sv
// Constants, register map and types for the dc-dc and battery control block
package dbc_pkg;
  localparam int ADDR_W = 9;
  localparam logic [7:0] IDX_POWERDOWN = 8'h0e;
  localparam logic [7:0] IDX_IND_DATA_LO = 8'h1c;
  localparam logic [7:0] IDX_IND_DATA_HI = 8'h1d;
  localparam logic [7:0] IDX_IND_ADDR = 8'h1e;
  localparam logic [7:0] IDX_IND_CTRL = 8'h1f;
  localparam logic [7:0] IDX_FEED_SEL = 8'h42;
  localparam logic [7:0] IDX_LINE_FEED = 8'h43;
  localparam logic [7:0] IDX_RING_BAT = 8'h4a;
  localparam logic [7:0] IDX_LOW_BAT = 8'h4b;
  localparam logic [7:0] IDX_PERIOD = 8'h5c;
  localparam logic [7:0] IDX_SW_DELAY = 8'h5d;
  localparam logic [7:0] IDX_OPTIONS = 8'h6c;
  localparam logic [7:0] IND_HEADROOM = 8'h29;
  localparam int BIT_CONV_OFF = 4;
  localparam int BIT_MANUAL_BATTERY_FEED_SELECT = 1;
  localparam int BIT_RANGE = 4;
  localparam int BIT_AUTO = 3;
  localparam int BIT_CAL = 7;
  localparam int BIT_FAST = 5;
  localparam int BIT_DEB = 3;
  localparam int BIT_FILT = 1;
  localparam logic [7:0] RST_POWERDOWN = 8'h10;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [15:0] RST_HEADROOM = 16'h0000;
  localparam logic [8:0] MIN_OFF_BASE = 9'h004;
  localparam logic [3:0] HEADROOM_MAX_NARROW = 4'h6;
  localparam logic [3:0] HEADROOM_MAX_WIDE = 4'h9;
  localparam logic signed [8:0] FAST_THRESH = 9'sh004;
  localparam logic [7:0] FAST_STEP = 8'h04;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEBOUNCE_MS = 60;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CAL_TIME_NS = 1000;
  localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    BS_HIGH = 3'b001,
    BS_DEB = 3'b010,
    BS_LOW = 3'b100
  } dbc_bsel_t;

  function automatic logic [ADDR_W-1:0] dbc_addr(input logic [7:0] idx);
    return {idx[6:0], 2'b00};
  endfunction
endpackage

// file: rtl/dbc_pwm_if.sv
// Carrier between the register side and the switching engine
`timescale 1ns/1ps
interface dbc_pwm_if;
  logic [7:0] period;
  logic [4:0] off_time;
  logic [7:0] width;
  logic enable;
  logic overload;
  logic drive;
  logic start;
  modport ctrl(output period, output off_time, output width, output enable, output overload,
    input drive, input start);
  modport core(input period, input off_time, input width, input enable, input overload,
    output drive, output start);
endinterface

// file: rtl/dbc_pwm_core.sv
// Switching period counter with minimum off time and overload cut-off
`timescale 1ns/1ps
module dbc_pwm_core
  import dbc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  dbc_pwm_if.core bus
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic ovl_reg;
  logic drive_reg;
  logic start_reg;
  logic last;
  logic [8:0] span;
  logic [8:0] off_min;
  logic [8:0] max_on;

  assign last = (cnt_reg == bus.period);
  assign span = {1'b0, bus.period} + 9'h001;
  assign off_min = {4'h0, bus.off_time} + MIN_OFF_BASE;
  assign max_on = (span > off_min) ? (span - off_min) : 9'h000;
  assign cnt_next = (!bus.enable || last) ? 8'h00 : cnt_reg + 8'h01;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= bus.enable && last;
    end
  end

  // Overload latch: a new hit on the boundary edge still wins
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovl_reg <= 1'b0;
    end else if (bus.overload) begin
      ovl_reg <= 1'b1;
    end else if (last) begin
      ovl_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= bus.enable && !bus.overload && !(ovl_reg && !last)
        && (cnt_next < bus.width) && ({1'b0, cnt_next} < max_on);
    end
  end

  assign bus.drive = drive_reg;
  assign bus.start = start_reg;

  logic [8:0] since_reg;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_reg <= 9'h000;
    end else if (start_reg || !bus.enable) begin
      since_reg <= 9'h001;
    end else if (since_reg != 9'h1ff) begin
      since_reg <= since_reg + 9'h001;
    end
  end

  logic armed_reg;
  logic [7:0] per_seen_reg;
  // Spacing only judged after one start under a steady period
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      armed_reg <= 1'b0;
      per_seen_reg <= 8'h00;
    end else begin
      per_seen_reg <= bus.period;
      armed_reg <= bus.enable && (bus.period == per_seen_reg) && (armed_reg || start_reg);
    end
  end

  AST_PERIOD_SPACING: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    start_reg && armed_reg |-> since_reg == span)
    else $error("period start spacing wrong");
  AST_OVERLOAD_CUT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (bus.overload || ovl_reg) && !last |=> !drive_reg)
    else $error("drive active after overload");
endmodule // dbc_pwm_core

// file: tb/dbc_stage_model.sv
// Behavioural power stage and overload monitors at the far side of the switch pins
`timescale 1ns/1ps
module dbc_stage_model (
  input wire logic i_core_clk,
  input wire logic i_drive,
  input wire logic [1:0] i_overload,
  output logic [5:0] o_sense,
  output logic o_mon_high,
  output logic o_mon_low
);
  logic [6:0] charge_reg;
  initial charge_reg = 7'h00;
  // Charge builds while switched on and leaks while off, so the loop settles mid-range
  always @(posedge i_core_clk) begin
    if (i_drive && charge_reg != 7'h7f) begin
      charge_reg <= charge_reg + 7'h01;
    end else if (!i_drive && charge_reg != 7'h00) begin
      charge_reg <= charge_reg - 7'h01;
    end
  end
  assign o_sense = charge_reg[6:1];
  assign o_mon_high = i_overload[0];
  assign o_mon_low = i_overload[1];
endmodule // dbc_stage_model

// file: tb/test_dbc_battery_ctrl.sv
// Self-checking bench for the dc-dc and battery control block
`timescale 1ns/1ps
module test_dbc_battery_ctrl;
  import dbc_pkg::*;
  localparam int DEB = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, mon_h, mon_l, drive, ff, low_sel, cal;
  logic ringing = 1'b0;
  logic off_hook = 1'b0;
  logic [5:0] act_tgt = 6'h14;
  logic [5:0] sense;
  logic [1:0] ovl = 2'b00;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int cmp_count = 0;
  int per, low_run, i;
  logic [7:0] ridx [12] = '{8'h0e, 8'h42, 8'h43, 8'h4a, 8'h4b, 8'h5c, 8'h5d, 8'h6c,
    8'h1c, 8'h1d, 8'h1e, 8'h1f};
  logic [7:0] rval [12] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};

  always #20 clk = ~clk;

  dbc_battery_ctrl #(.DEBOUNCE_LEN(DEB)) DUT (.i_core_clk(clk), .i_resetn(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_battery_sense_in(sense), .i_supply_monitor_high(mon_h),
    .i_supply_monitor_low(mon_l), .i_ringing(ringing), .i_off_hook(off_hook),
    .i_active_target(act_tgt), .o_switch_drive_out(drive),
    .o_switch_feedforward_out(ff), .o_low_battery_sel(low_sel),
    .o_monitor_calibrate(cal));

  dbc_stage_model stage (.i_core_clk(clk), .i_drive(drive), .i_overload(ovl),
    .o_sense(sense), .o_mon_high(mon_h), .o_mon_low(mon_l));

  task automatic stop_test;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic fail_wait(input string name);
    $display("mismatch %s expected handshake seen timeout", name);
    error_cnt++;
    stop_test();
  endtask

  // Called just after a rising edge; request held until pready is sampled high,
  // then one idle edge so back-to-back calls never drive psel twice at once
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] data);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[6:0], 2'b00};
    pwdata <= {24'h00_0000, data};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) fail_wait("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, {24'h00_0000, exp}, rd);
    chk("pslverr", 32'h0000_0000, {31'h0000_0000, err});
  endtask

  task automatic wait_rise;
    logic prev;
    int n;
    prev = 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if (drive === 1'b1 && prev === 1'b0) break;
      prev = drive;
    end
    if (n == 2000) fail_wait("drive");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    chk("drive in reset", 32'h0000_0000, {31'h0000_0000, drive});
    chk("feedforward in reset", 32'h0000_0001, {31'h0000_0000, ff});
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 12; i++) rdchk("reset value", ridx[i], rval[i]);
    apb(1'b0, 8'h01, 8'h00);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    pstrb <= 4'h0;
    apb(1'b1, 8'h5c, 8'h55);
    pstrb <= 4'hf;
    rdchk("strobe off write", 8'h5c, 8'hff);
    apb(1'b1, 8'h5c, 8'h1f);
    apb(1'b1, 8'h5d, 8'h7f);
    rdchk("off time field", 8'h5d, 8'h1f);
    apb(1'b1, 8'h5d, 8'h05);
    apb(1'b1, 8'h4a, 8'h3f);
    rdchk("high battery", 8'h4a, 8'h3f);
    apb(1'b1, 8'h4b, 8'h0a);
    apb(1'b1, 8'h6c, 8'h22);
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (drive !== 1'b0) break;
    end
    chk("drive while off", 32'h0000_0028, i);
    apb(1'b1, 8'h0e, 8'h00);
    repeat (4) wait_rise();
    per = 0;
    low_run = 0;
    wait_rise();
    for (per = 1; per < 600; per++) begin
      @(posedge clk);
      if (drive === 1'b1 && low_run > 0) break;
      if (drive === 1'b0) low_run++;
    end
    chk("period", 32'h0000_0020, per);
    chk("min off", 32'h0000_0001, {31'h0000_0000, low_run >= 9});
    chk("feedforward", {31'h0000_0000, ~drive}, {31'h0000_0000, ff});
    for (int k = 0; k < 2; k++) begin
      wait_rise();
      ovl <= (k == 0) ? 2'b01 : 2'b10;
      for (i = 1; i < 100; i++) begin
        @(posedge clk);
        if (i == 2) ovl <= 2'b00;
        if (i >= 5 && drive === 1'b1) break;
      end
      chk("overload cut", 32'h0000_0020, i);
    end
    apb(1'b1, 8'h42, 8'h02);
    repeat (3) @(posedge clk);
    chk("manual low", 32'h0000_0001, {31'h0000_0000, low_sel});
    apb(1'b1, 8'h42, 8'h00);
    repeat (3) @(posedge clk);
    chk("manual high", 32'h0000_0000, {31'h0000_0000, low_sel});
    apb(1'b1, 8'h43, 8'h08);
    off_hook <= 1'b1;
    repeat (3) @(posedge clk);
    chk("auto off-hook", 32'h0000_0001, {31'h0000_0000, low_sel});
    ringing <= 1'b1;
    repeat (3) @(posedge clk);
    chk("auto ringing", 32'h0000_0000, {31'h0000_0000, low_sel});
    ringing <= 1'b0;
    repeat (3) @(posedge clk);
    chk("after ringing", 32'h0000_0001, {31'h0000_0000, low_sel});
    off_hook <= 1'b0;
    repeat (3) @(posedge clk);
    chk("auto on-hook", 32'h0000_0000, {31'h0000_0000, low_sel});
    apb(1'b1, 8'h6c, 8'h2a);
    off_hook <= 1'b1;
    repeat (DEB / 2) @(posedge clk);
    chk("debounce hold", 32'h0000_0000, {31'h0000_0000, low_sel});
    repeat (DEB) @(posedge clk);
    chk("debounce done", 32'h0000_0001, {31'h0000_0000, low_sel});
    off_hook <= 1'b0;
    repeat (3) @(posedge clk);
    off_hook <= 1'b1;
    repeat (DEB / 2) @(posedge clk);
    off_hook <= 1'b0;
    repeat (DEB + 5) @(posedge clk);
    chk("debounce cancel", 32'h0000_0000, {31'h0000_0000, low_sel});
    apb(1'b1, 8'h1e, 8'h29);
    rdchk("indirect empty", 8'h1c, 8'h00);
    apb(1'b1, 8'h1c, 8'h0b);
    apb(1'b1, 8'h1d, 8'h00);
    apb(1'b1, 8'h1f, 8'h00);
    apb(1'b1, 8'h1c, 8'h00);
    apb(1'b1, 8'h1e, 8'h29);
    rdchk("indirect low", 8'h1c, 8'h0b);
    rdchk("indirect high", 8'h1d, 8'h00);
    rdchk("indirect status", 8'h1f, 8'h00);
    apb(1'b1, 8'h5d, 8'h85);
    repeat (2) @(posedge clk);
    chk("calibrating", 32'h0000_0001, {31'h0000_0000, cal});
    repeat (30) @(posedge clk);
    chk("calibration end", 32'h0000_0000, {31'h0000_0000, cal});
    rdchk("calibration status", 8'h5d, 8'h05);
    apb(1'b1, 8'h0e, 8'h10);
    repeat (2) @(posedge clk);
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (drive !== 1'b0) break;
    end
    chk("drive after power-off", 32'h0000_0028, i);
    stop_test();
  end
endmodule // test_dbc_battery_ctrl
